// ---- design/tcm_pkg.sv ----
package tcm_pkg;

  // Channel message layout, bit 0 is the first bit received on the link
  localparam int TCM_MSG_BITS = 15;
  localparam int TCM_START_LSB = 0;
  localparam int TCM_START_W = 3;
  localparam int TCM_PARITY_POS = 3;
  localparam int TCM_DATA_LSB = 4;
  localparam int TCM_DATA_W = 8;
  localparam int TCM_PORTS = 4;

  // Start codes; bit 0 must be one because it frames the message
  localparam logic [2:0] TCM_START_NORMAL = 3'h5;
  localparam logic [2:0] TCM_START_MAINT = 3'h7;

  // Field positions of the port status inside a control message data byte
  localparam int TCM_EN_FIELD_LSB = 0;
  localparam int TCM_TEST_FIELD_LSB = 4;

  // Timing of the buffer initialise pulse
  localparam int TCM_CLK_PERIOD_NS = 8;
  localparam int TCM_INIT_PULSE_NS = 500;
  localparam int TCM_INIT_PULSE_CYC = (TCM_INIT_PULSE_NS + TCM_CLK_PERIOD_NS - 1) / TCM_CLK_PERIOD_NS;
  localparam int TCM_INIT_CNT_W = 7;

  // Register port map and reset values
  localparam logic [7:0] TCM_REG_LINE_STATUS = 8'h00;
  localparam logic [7:0] TCM_REG_CHAN_STATE = 8'h04;
  localparam logic [3:0] TCM_EN_RST = 4'h0;
  localparam logic [3:0] TCM_TEST_RST = 4'h0;

  // Channel sequencer, Gray coded along receive, process, forward, reply
  typedef enum logic [2:0] {
    TCM_RECV = 3'h0,
    TCM_PROC = 3'h1,
    TCM_FWD_CLR = 3'h3,
    TCM_FWD_GATE = 3'h2,
    TCM_FWD_START = 3'h6,
    TCM_LOAD = 3'h7,
    TCM_SEND = 3'h5,
    TCM_INIT = 3'h4
  } tcm_state_t;

endpackage

// ---- design/tcm_channel_ctrl.sv ----
`timescale 1ns/1ns
module tcm_channel_ctrl #(
  parameter logic [2:0] START_NORMAL = tcm_pkg::TCM_START_NORMAL,
  parameter logic [2:0] START_MAINT = tcm_pkg::TCM_START_MAINT,
  parameter int EN_FIELD_LSB = tcm_pkg::TCM_EN_FIELD_LSB,
  parameter int TEST_FIELD_LSB = tcm_pkg::TCM_TEST_FIELD_LSB
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic CTRL_A_CARRIER_I,
  input wire logic [1:0] CTRL_A_RX_I,
  input wire logic CTRL_A_BIT_STB_I,
  input wire logic CTRL_B_CARRIER_I,
  input wire logic [1:0] CTRL_B_RX_I,
  input wire logic CTRL_B_BIT_STB_I,
  input wire logic CHAR_READY_FLAG_N_I,
  input wire logic LINE_IDLE_STATE_I,
  input wire logic [7:0] LINE_REG_REPLY_DATA_I,
  input wire logic [tcm_pkg::TCM_PORTS-1:0] PORT_ALARM_INPUTS_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic DATA_PRESENT_N_O,
  output logic BUFFER_INIT_PULSE_O,
  output logic SELECT_CTRL_A_N_O,
  output logic SELECT_CTRL_B_N_O,
  output logic INHIBIT_CTRL_A_N_O,
  output logic INHIBIT_CTRL_B_N_O,
  output logic SERIAL_IN_DATA_O,
  output logic SHIFT_STROBE_N_O,
  output logic SERIAL_REPLY_DATA_O,
  output logic TX_ENABLE_CTRL_A_N_O,
  output logic TX_ENABLE_CTRL_B_N_O,
  output logic [1:0] TX_PAIR_CTRL_A_O,
  output logic [1:0] TX_PAIR_CTRL_B_O,
  output logic DEMAND_INTERRUPT_N_O,
  output logic LINE_BUF_CLEAR_N_O,
  output logic [7:0] CHAN_TO_LINE_DATA_O,
  output logic CHAN_TO_LINE_GATE_N_O,
  output logic LINE_START_N_O,
  output logic [tcm_pkg::TCM_PORTS-1:0] PORT_ENABLE_LINES_N_O,
  output logic [7:0] LINE_STATUS_O
);
  import tcm_pkg::*;

  // Odd parity over a whole message: true when the count of ones is odd
  function automatic logic odd_ok(input logic [TCM_MSG_BITS-1:0] m);
    odd_ok = ^m;
  endfunction

  // Builds a 15-bit message with generated odd parity and zero tail
  function automatic logic [TCM_MSG_BITS-1:0] build_msg(input logic [2:0] code, input logic [7:0] data);
    logic [TCM_MSG_BITS-1:0] m;
    m = '0;
    m[TCM_START_LSB +: TCM_START_W] = code;
    m[TCM_DATA_LSB +: TCM_DATA_W] = data;
    m[TCM_PARITY_POS] = ~(^m);
    build_msg = m;
  endfunction

  tcm_state_t state_q, state_d;
  logic [1:0] active_q;
  logic [TCM_MSG_BITS-1:0] buf_q, buf_d;
  logic strobe_n_q;
  logic in_bit_q;
  logic [TCM_INIT_CNT_W-1:0] init_cnt_q;
  logic [3:0] en_q;
  logic [3:0] en_n_q;
  logic [3:0] test_q;
  logic [3:0] alarm_q;
  logic reply_char_q;
  logic ami_pol_q;
  logic [1:0] pair_a_q, pair_b_q;
  logic reply_bit_q;
  logic [7:0] rdata_q;
  logic dp_n_q, init_o_q, sel_a_n_q, sel_b_n_q, txen_a_n_q, txen_b_n_q;
  logic demand_n_q, lb_clr_n_q, gate_n_q, start_n_q;
  logic [7:0] c2l_q;

  // Only the selected controller's input is gated through; the other is inhibited
  wire logic pick_a = (active_q == 2'b00) && (state_q == TCM_RECV) && CTRL_A_CARRIER_I;
  wire logic pick_b = (active_q == 2'b00) && (state_q == TCM_RECV) && !CTRL_A_CARRIER_I && CTRL_B_CARRIER_I;
  wire logic rx_stb = (active_q[0] & CTRL_A_BIT_STB_I) | (active_q[1] & CTRL_B_BIT_STB_I);
  wire logic rx_bit = (active_q[0] & (|CTRL_A_RX_I)) | (active_q[1] & (|CTRL_B_RX_I));
  wire logic carrier = (active_q[0] & CTRL_A_CARRIER_I) | (active_q[1] & CTRL_B_CARRIER_I);
  wire logic msg_end = (|active_q) && !carrier && (state_q != TCM_INIT);
  wire logic shift_edge = !strobe_n_q;

  // Decode of a framed message
  wire logic [2:0] rx_code = buf_q[TCM_START_LSB +: TCM_START_W];
  wire logic [7:0] rx_data = buf_q[TCM_DATA_LSB +: TCM_DATA_W];
  wire logic par_good = odd_ok(buf_q);
  wire logic is_char = par_good && (rx_code == START_NORMAL);
  wire logic is_ctrl = par_good && (rx_code == START_MAINT);
  wire logic char_ready = !CHAR_READY_FLAG_N_I;
  wire logic do_fwd = is_char && !char_ready && LINE_IDLE_STATE_I;
  wire logic upd_status = (state_q == TCM_PROC) && is_ctrl;
  wire logic reg_wr_stat = REG_WR_I && (REG_ADDR_I == TCM_REG_LINE_STATUS);
  // Next status values; the alarm bits use test_d so a status reply right after an update is current
  wire logic [3:0] en_d = upd_status ? rx_data[EN_FIELD_LSB +: 4] :
    (reg_wr_stat ? REG_WDATA_I[3:0] : en_q);
  wire logic [3:0] test_d = upd_status ? rx_data[TEST_FIELD_LSB +: 4] :
    (reg_wr_stat ? REG_WDATA_I[7:4] : test_q);
  wire logic init_done = (init_cnt_q == TCM_INIT_CNT_W'(TCM_INIT_PULSE_CYC - 1));
  wire logic [7:0] status_byte = {alarm_q, en_q};
  wire logic [7:0] reply_data = reply_char_q ? LINE_REG_REPLY_DATA_I : status_byte;
  wire logic [2:0] reply_code = reply_char_q ? START_NORMAL : START_MAINT;

  // Sequencer next state and channel buffer next value
  always_comb begin
    state_d = state_q;
    buf_d = buf_q;
    case (state_q)
      TCM_RECV: begin
        if (msg_end) begin
          state_d = TCM_INIT;
        end else if (buf_q[0]) begin
          state_d = TCM_PROC;
        end else if (shift_edge) begin
          buf_d = {in_bit_q, buf_q[TCM_MSG_BITS-1:1]};
        end
      end
      TCM_PROC: begin
        // Bad parity or unknown start code takes no action and answers with status
        state_d = do_fwd ? TCM_FWD_CLR : TCM_LOAD;
      end
      TCM_FWD_CLR: begin
        state_d = TCM_FWD_GATE;
      end
      TCM_FWD_GATE: begin
        state_d = TCM_FWD_START;
      end
      TCM_FWD_START: begin
        state_d = TCM_LOAD;
      end
      TCM_LOAD: begin
        buf_d = build_msg(reply_code, reply_data);
        state_d = TCM_SEND;
      end
      TCM_SEND: begin
        if (msg_end) begin
          state_d = TCM_INIT;
        end else if (shift_edge) begin
          buf_d = {1'b0, buf_q[TCM_MSG_BITS-1:1]};
        end
      end
      TCM_INIT: begin
        buf_d = '0;
        if (init_done) begin
          state_d = TCM_RECV;
        end
      end
      default: begin
        state_d = TCM_INIT;
      end
    endcase
    // An end of data in the middle of processing still forces re-initialise
    if (msg_end) begin
      state_d = TCM_INIT;
    end
  end

  // Sequencer registers
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= TCM_RECV;
      buf_q <= '0;
    end else begin
      state_q <= state_d;
      buf_q <= buf_d;
    end
  end

  // Controller selection; released only when the init pulse starts
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      active_q <= 2'b00;
    end else if (state_d == TCM_INIT) begin
      active_q <= 2'b00;
    end else if (pick_a | pick_b) begin
      active_q <= {pick_b, pick_a};
    end
  end

  // Recovered strobe: low one cycle per bit, shift happens as it returns high
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      strobe_n_q <= 1'b1;
      in_bit_q <= 1'b0;
      dp_n_q <= 1'b1;
    end else begin
      strobe_n_q <= !rx_stb;
      in_bit_q <= rx_bit;
      dp_n_q <= !carrier;
    end
  end

  // Init pulse length counter
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      init_cnt_q <= '0;
    end else if (state_q == TCM_INIT) begin
      init_cnt_q <= init_cnt_q + TCM_INIT_CNT_W'(1);
    end else begin
      init_cnt_q <= '0;
    end
  end

  // Line status: a control message has priority over a register write in the same cycle
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_q <= TCM_EN_RST;
      en_n_q <= ~TCM_EN_RST;
      test_q <= TCM_TEST_RST;
    end else begin
      en_q <= en_d;
      en_n_q <= ~en_d;
      test_q <= test_d;
    end
  end

  // Alarm bits track the inputs, or a forced test condition
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      alarm_q <= 4'h0;
    end else begin
      alarm_q <= PORT_ALARM_INPUTS_I | test_d;
    end
  end

  // Reply kind latched from the ready flag seen at framing
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      reply_char_q <= 1'b0;
    end else if (state_q == TCM_PROC) begin
      reply_char_q <= char_ready && (is_char || is_ctrl);
    end
  end

  // Select, inhibit and transmit enable lines, all registered
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sel_a_n_q <= 1'b1;
      sel_b_n_q <= 1'b1;
      txen_a_n_q <= 1'b1;
      txen_b_n_q <= 1'b1;
    end else begin
      sel_a_n_q <= !(pick_a | (active_q[0] & (state_d != TCM_INIT)));
      sel_b_n_q <= !(pick_b | (active_q[1] & (state_d != TCM_INIT)));
      txen_a_n_q <= !(active_q[0] & (state_d == TCM_SEND));
      txen_b_n_q <= !(active_q[1] & (state_d == TCM_SEND));
    end
  end

  // Serial reply with alternate-mark bipolar pairs; a one flips the pulse polarity
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      reply_bit_q <= 1'b0;
      ami_pol_q <= 1'b0;
      pair_a_q <= 2'b00;
      pair_b_q <= 2'b00;
    end else if ((state_q == TCM_SEND) && shift_edge && !msg_end) begin
      reply_bit_q <= buf_q[0];
      ami_pol_q <= ami_pol_q ^ buf_q[0];
      pair_a_q <= (active_q[0] & buf_q[0]) ? {!ami_pol_q, ami_pol_q} : 2'b00;
      pair_b_q <= (active_q[1] & buf_q[0]) ? {!ami_pol_q, ami_pol_q} : 2'b00;
    end else if ((state_q != TCM_SEND) || msg_end) begin
      // A cut frame must not leave a pulse standing on a disabled pair
      reply_bit_q <= 1'b0;
      pair_a_q <= 2'b00;
      pair_b_q <= 2'b00;
    end
  end

  // Line controller handshake; each strobe is one cycle wide
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lb_clr_n_q <= 1'b1;
      gate_n_q <= 1'b1;
      start_n_q <= 1'b1;
      c2l_q <= 8'h00;
      init_o_q <= 1'b0;
      demand_n_q <= 1'b1;
    end else begin
      lb_clr_n_q <= (state_d != TCM_FWD_CLR);
      gate_n_q <= (state_d != TCM_FWD_GATE);
      start_n_q <= (state_d != TCM_FWD_START);
      if (state_q == TCM_FWD_CLR) begin
        c2l_q <= rx_data;
      end
      init_o_q <= (state_d == TCM_INIT);
      demand_n_q <= CHAR_READY_FLAG_N_I;
    end
  end

  // Register port read data, valid the cycle after the read strobe
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_q <= 8'h00;
    end else if (REG_RD_I && (REG_ADDR_I == TCM_REG_LINE_STATUS)) begin
      rdata_q <= status_byte;
    end else if (REG_RD_I && (REG_ADDR_I == TCM_REG_CHAN_STATE)) begin
      rdata_q <= {1'b0, reply_char_q, active_q, 1'b0, state_q};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign REG_RDATA_O = rdata_q;
  assign DATA_PRESENT_N_O = dp_n_q;
  assign BUFFER_INIT_PULSE_O = init_o_q;
  assign SELECT_CTRL_A_N_O = sel_a_n_q;
  assign SELECT_CTRL_B_N_O = sel_b_n_q;
  assign INHIBIT_CTRL_A_N_O = sel_b_n_q;
  assign INHIBIT_CTRL_B_N_O = sel_a_n_q;
  assign SERIAL_IN_DATA_O = in_bit_q;
  assign SHIFT_STROBE_N_O = strobe_n_q;
  assign SERIAL_REPLY_DATA_O = reply_bit_q;
  assign TX_ENABLE_CTRL_A_N_O = txen_a_n_q;
  assign TX_ENABLE_CTRL_B_N_O = txen_b_n_q;
  assign TX_PAIR_CTRL_A_O = pair_a_q;
  assign TX_PAIR_CTRL_B_O = pair_b_q;
  assign DEMAND_INTERRUPT_N_O = demand_n_q;
  assign LINE_BUF_CLEAR_N_O = lb_clr_n_q;
  assign CHAN_TO_LINE_DATA_O = c2l_q;
  assign CHAN_TO_LINE_GATE_N_O = gate_n_q;
  assign LINE_START_N_O = start_n_q;
  assign PORT_ENABLE_LINES_N_O = en_n_q;
  assign LINE_STATUS_O = status_byte;

endmodule

// ---- sim/tcm_channel_props.sv ----
`timescale 1ns/1ns
module tcm_channel_props
  import tcm_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic CHAR_READY_FLAG_N_I,
  input wire logic [TCM_PORTS-1:0] PORT_ALARM_INPUTS_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic DATA_PRESENT_N_O,
  input wire logic BUFFER_INIT_PULSE_O,
  input wire logic SELECT_CTRL_A_N_O,
  input wire logic SELECT_CTRL_B_N_O,
  input wire logic INHIBIT_CTRL_A_N_O,
  input wire logic INHIBIT_CTRL_B_N_O,
  input wire logic SHIFT_STROBE_N_O,
  input wire logic SERIAL_REPLY_DATA_O,
  input wire logic TX_ENABLE_CTRL_A_N_O,
  input wire logic TX_ENABLE_CTRL_B_N_O,
  input wire logic [1:0] TX_PAIR_CTRL_A_O,
  input wire logic [1:0] TX_PAIR_CTRL_B_O,
  input wire logic DEMAND_INTERRUPT_N_O,
  input wire logic LINE_BUF_CLEAR_N_O,
  input wire logic CHAN_TO_LINE_GATE_N_O,
  input wire logic LINE_START_N_O,
  input wire logic [TCM_PORTS-1:0] PORT_ENABLE_LINES_N_O,
  input wire logic [7:0] LINE_STATUS_O
);
  logic [6:0] init_cnt_q;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Length of the init pulse, counted so the figure need not be unrolled
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      init_cnt_q <= 7'h00;
    end else begin
      init_cnt_q <= BUFFER_INIT_PULSE_O ? init_cnt_q + 7'h01 : 7'h00;
    end
  end
  a_init_pulse_len: assert property ($fell(BUFFER_INIT_PULSE_O) |-> init_cnt_q == TCM_INIT_PULSE_CYC)
    else $error("init pulse length wrong");
  a_init_after_drop: assert property ($rose(DATA_PRESENT_N_O) |-> ##[0:2] BUFFER_INIT_PULSE_O)
    else $error("no init pulse after data ends");
  a_one_select: assert property (SELECT_CTRL_A_N_O || SELECT_CTRL_B_N_O)
    else $error("both controllers selected");
  a_inhibit_mirror: assert property (INHIBIT_CTRL_B_N_O == SELECT_CTRL_A_N_O && INHIBIT_CTRL_A_N_O == SELECT_CTRL_B_N_O)
    else $error("inhibit does not follow select");
  a_strobe_single: assert property (!SHIFT_STROBE_N_O |=> SHIFT_STROBE_N_O)
    else $error("shift strobe longer than one cycle");
  a_tx_routed: assert property ((!TX_ENABLE_CTRL_A_N_O |-> !SELECT_CTRL_A_N_O && TX_ENABLE_CTRL_B_N_O) and
    (!TX_ENABLE_CTRL_B_N_O |-> !SELECT_CTRL_B_N_O))
    else $error("transmit enable not on active controller");
  a_pair_quiet: assert property ((TX_ENABLE_CTRL_A_N_O |-> TX_PAIR_CTRL_A_O == 2'h0) and
    (TX_ENABLE_CTRL_B_N_O |-> TX_PAIR_CTRL_B_O == 2'h0) and $onehot0(TX_PAIR_CTRL_A_O))
    else $error("reply pair driven while disabled");
  a_reply_bit_pair: assert property (SERIAL_REPLY_DATA_O == ((|TX_PAIR_CTRL_A_O) || (|TX_PAIR_CTRL_B_O)))
    else $error("reply bit and transmit pair disagree");
  a_demand_mirror: assert property ($past(RST_N_I) |-> DEMAND_INTERRUPT_N_O == $past(CHAR_READY_FLAG_N_I))
    else $error("demand interrupt does not follow ready flag");
  a_fwd_order: assert property (!LINE_START_N_O |-> !$past(CHAN_TO_LINE_GATE_N_O) && !$past(LINE_BUF_CLEAR_N_O, 2))
    else $error("line start without clear and gate");
  a_enable_lines: assert property (PORT_ENABLE_LINES_N_O == ~LINE_STATUS_O[3:0])
    else $error("port enable lines differ from status");
  a_alarm_follow: assert property ($past(RST_N_I) && $stable(PORT_ALARM_INPUTS_I) |=>
    (LINE_STATUS_O[7:4] & $past(PORT_ALARM_INPUTS_I)) == $past(PORT_ALARM_INPUTS_I))
    else $error("alarm bit does not follow input");
  a_rdata_idle: assert property ($past(RST_N_I) && !$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data outside read cycle");
  // Main scenarios reached
  c_forward: cover property (!LINE_START_N_O);
  c_reply_a: cover property (!TX_ENABLE_CTRL_A_N_O);
  c_reply_b: cover property (!TX_ENABLE_CTRL_B_N_O);
endmodule

bind tcm_channel_ctrl tcm_channel_props u_props (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
  .CHAR_READY_FLAG_N_I(CHAR_READY_FLAG_N_I), .PORT_ALARM_INPUTS_I(PORT_ALARM_INPUTS_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .DATA_PRESENT_N_O(DATA_PRESENT_N_O), .BUFFER_INIT_PULSE_O(BUFFER_INIT_PULSE_O),
  .SELECT_CTRL_A_N_O(SELECT_CTRL_A_N_O), .SELECT_CTRL_B_N_O(SELECT_CTRL_B_N_O),
  .INHIBIT_CTRL_A_N_O(INHIBIT_CTRL_A_N_O), .INHIBIT_CTRL_B_N_O(INHIBIT_CTRL_B_N_O),
  .SHIFT_STROBE_N_O(SHIFT_STROBE_N_O), .SERIAL_REPLY_DATA_O(SERIAL_REPLY_DATA_O),
  .TX_ENABLE_CTRL_A_N_O(TX_ENABLE_CTRL_A_N_O),
  .TX_ENABLE_CTRL_B_N_O(TX_ENABLE_CTRL_B_N_O), .TX_PAIR_CTRL_A_O(TX_PAIR_CTRL_A_O),
  .TX_PAIR_CTRL_B_O(TX_PAIR_CTRL_B_O), .DEMAND_INTERRUPT_N_O(DEMAND_INTERRUPT_N_O),
  .LINE_BUF_CLEAR_N_O(LINE_BUF_CLEAR_N_O), .CHAN_TO_LINE_GATE_N_O(CHAN_TO_LINE_GATE_N_O),
  .LINE_START_N_O(LINE_START_N_O), .PORT_ENABLE_LINES_N_O(PORT_ENABLE_LINES_N_O), .LINE_STATUS_O(LINE_STATUS_O));

// ---- sim/tcm_cc_model.sv ----
`timescale 1ns/1ns
module tcm_cc_model (
  input wire logic clk_i,
  input wire logic [1:0] tx_i,
  output logic carrier_o,
  output logic [1:0] rx_o,
  output logic stb_o,
  output logic [14:0] reply_o,
  output logic reply_v_o
);
  logic pol_q;
  initial begin
    carrier_o = 1'b0;
    rx_o = 2'h1;
    stb_o = 1'b0;
    reply_o = 15'h0000;
    reply_v_o = 1'b0;
    pol_q = 1'b0;
  end
  // Outside a frame the pair keeps toggling so a stale bit never reads as data
  always @(posedge clk_i) begin
    if (!carrier_o) begin
      rx_o <= ~rx_o;
    end
  end
  // One message, then a zero stream that clocks the reply back; gap sets the bit rate
  task automatic send(input logic [14:0] msg, input int gap);
    int n;
    logic b;
    logic [14:0] r;
    n = 0;
    r = 15'h0000;
    carrier_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 45; i++) begin
      if (i > 15 && n < 15 && (n > 0 || tx_i != 2'h0)) begin
        r[n] = |tx_i;
        n++;
      end
      b = (i < 15) ? msg[i] : 1'b0;
      rx_o <= b ? (pol_q ? 2'b01 : 2'b10) : 2'b00;
      pol_q = pol_q ^ b;
      stb_o <= 1'b1;
      @(posedge clk_i);
      stb_o <= 1'b0;
      repeat (gap) @(posedge clk_i);
    end
    carrier_o <= 1'b0;
    reply_o <= r;
    reply_v_o <= 1'b1;
    @(posedge clk_i);
    reply_v_o <= 1'b0;
    repeat (80) @(posedge clk_i);
  endtask
endmodule

// ---- sim/tty_channel_message_controller_tb.sv ----
`timescale 1ns/1ns
module tty_channel_message_controller_tb;
  import tcm_pkg::*;
  logic clk, rst_n, rdy_n, idle, wr, rd, rd_q, ca, cb, sa, sb, rav, rbv, start_n;
  logic [1:0] rxa, rxb, txa, txb;
  logic [3:0] alarm, en_m, tst_m, al;
  logic [7:0] lreg, addr, wdata, rdata, c2l, d, lr;
  logic [14:0] repa, repb, m;
  logic [14:0] exp_rep[$], exp_chr[$], exp_rd[$];
  int errors, check_count, seed;
  bit ctl, ready, bad;
  tcm_channel_ctrl dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .CTRL_A_CARRIER_I(ca), .CTRL_A_RX_I(rxa),
    .CTRL_A_BIT_STB_I(sa), .CTRL_B_CARRIER_I(cb), .CTRL_B_RX_I(rxb), .CTRL_B_BIT_STB_I(sb),
    .CHAR_READY_FLAG_N_I(rdy_n), .LINE_IDLE_STATE_I(idle), .LINE_REG_REPLY_DATA_I(lreg),
    .PORT_ALARM_INPUTS_I(alarm), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .DATA_PRESENT_N_O(), .BUFFER_INIT_PULSE_O(), .SELECT_CTRL_A_N_O(),
    .SELECT_CTRL_B_N_O(), .INHIBIT_CTRL_A_N_O(), .INHIBIT_CTRL_B_N_O(), .SERIAL_IN_DATA_O(),
    .SHIFT_STROBE_N_O(), .SERIAL_REPLY_DATA_O(), .TX_ENABLE_CTRL_A_N_O(), .TX_ENABLE_CTRL_B_N_O(),
    .TX_PAIR_CTRL_A_O(txa), .TX_PAIR_CTRL_B_O(txb), .DEMAND_INTERRUPT_N_O(), .LINE_BUF_CLEAR_N_O(),
    .CHAN_TO_LINE_DATA_O(c2l), .CHAN_TO_LINE_GATE_N_O(), .LINE_START_N_O(start_n),
    .PORT_ENABLE_LINES_N_O(), .LINE_STATUS_O());
  tcm_cc_model u_cca (.clk_i(clk), .tx_i(txa), .carrier_o(ca), .rx_o(rxa), .stb_o(sa), .reply_o(repa), .reply_v_o(rav));
  tcm_cc_model u_ccb (.clk_i(clk), .tx_i(txb), .carrier_o(cb), .rx_o(rxb), .stb_o(sb), .reply_o(repb), .reply_v_o(rbv));
  // Free-running reference clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Message with odd parity over all fifteen bits
  function automatic logic [14:0] mk(input logic [2:0] s, input logic [7:0] dd);
    return {3'h0, dd, ~(^{s, dd}), s};
  endfunction
  task cmp(input string nm, input logic [14:0] e, input logic [14:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One compare task per kind of result
  task cmp_reply(input logic [14:0] e, input logic [14:0] g);
    cmp("reply", e, g);
  endtask
  task cmp_fwd(input logic [14:0] e, input logic [14:0] g);
    cmp("forward", e, g);
  endtask
  task cmp_rd(input logic [14:0] e, input logic [14:0] g);
    cmp("rdata", e, g);
  endtask
  // Register access; the trailing edge keeps two strobes from meeting in one step
  task acc(input logic w, input logic [7:0] a, input logic [7:0] dd, input logic [7:0] e);
    if (!w) exp_rd.push_back({7'h00, e});
    addr <= a;
    wdata <= dd;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task stop_test;
    errors += exp_rep.size() + exp_chr.size() + exp_rd.size();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Results are matched against the oldest note as they appear
  always @(posedge clk) begin
    rd_q <= rd;
    if (rav === 1'b1 || rbv === 1'b1) cmp_reply(exp_rep.pop_front(), rav ? repa : repb);
    if (start_n === 1'b0) cmp_fwd(exp_chr.pop_front(), {7'h00, c2l});
    if (rd_q === 1'b1) cmp_rd(exp_rd.pop_front(), {7'h00, rdata});
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
  // Walk through every row of the action table, both controllers, two bit rates
  initial begin
    {rst_n, rdy_n, idle, wr, rd, rd_q, lreg, alarm, addr, wdata} = 0;
    {en_m, tst_m, errors, check_count} = 0;
    seed = 32'h4cfe;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      d = $random(seed);
      lr = $random(seed);
      al = $random(seed);
      bad = i > 7;
      ctl = i < 4 || i == 8;
      ready = i[1] ^ bad;
      rdy_n <= !ready;
      idle <= i[0];
      lreg <= lr;
      alarm <= al;
      repeat (4) @(posedge clk);
      m = mk(ctl ? TCM_START_MAINT : TCM_START_NORMAL, d);
      m[3] = m[3] ^ bad;
      if (!bad && ctl) {tst_m, en_m} = d;
      if (!bad && !ctl && !ready && i[0]) exp_chr.push_back({7'h00, d});
      exp_rep.push_back((!bad && ready) ? mk(TCM_START_NORMAL, lr) : mk(TCM_START_MAINT, {al | tst_m, en_m}));
      if (i % 3 == 1) u_ccb.send(m, 3 + i % 2 * 4);
      else u_cca.send(m, 3 + i % 2 * 4);
      acc(1'b0, TCM_REG_LINE_STATUS, 8'h00, {al | tst_m, en_m});
      $display("test %0d done", i);
    end
    acc(1'b1, TCM_REG_LINE_STATUS, 8'hA6, 8'h00);
    acc(1'b0, TCM_REG_LINE_STATUS, 8'h00, {al | 4'hA, 4'h6});
    acc(1'b0, 8'h10, 8'h00, 8'h00);
    acc(1'b0, TCM_REG_CHAN_STATE, 8'h00, 8'h00);
    $display("test registers done");
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule
